// ===== sim/mer_memory_error_response_tb_top.sv
// Testbench for the memory error response block.
`timescale 1ns/1ps

module mer_memory_error_response_tb_top
	import mer_pkg::*;
;
	typedef struct packed {
		mer_op_t op;
		logic [7:0] addr;
		logic [31:0] wdata;
		logic [31:0] flip;
		logic [3:0] en;
		logic [1:0] st;
		logic eri;
		logic [2:0] ev;
	} mer_row_t;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic eri_en = 1'b0;
	logic rd_x = 1'b0;
	logic defer = 1'b0;
	logic valid = 1'b0;
	mer_req_t req = '0;
	logic ready;
	logic rsp_v;
	mer_rsp_t rsp;
	logic fhi;
	logic eri;
	logic rec_v;
	mer_rec_t rec;
	logic [7:0] done_cnt;
	logic [7:0] err_cnt;
	int bad_count = 0;
	int n_tests = 0;
	// Enable order in each row: read response, write response, write interrupt, defer.
	// Read pulses are enabled with the read response; ev is fault pulse, record, uncontainable.
	// A poisoned word read with every gate off comes back exactly as it was stored.
	mer_row_t rows [13] = '{
		'{OP_WRITE, 8'h10, 32'hA5A5A5A5, 32'h0, 4'h0, RESP_OKAY, 1'b0, 3'h0},
		'{OP_READ, 8'h10, 32'hA5A5A5A5, 32'h0, 4'hF, RESP_OKAY, 1'b0, 3'h0},
		'{OP_CMO, 8'h10, 32'h0, 32'h0, 4'hF, RESP_OKAY, 1'b0, 3'h0},
		'{OP_WRITE, 8'h11, 32'h12345678, 32'h1, 4'h6, RESP_ERROR, 1'b1, 3'h2},
		'{OP_READ, 8'h11, 32'h12345678, 32'h0, 4'h0, RESP_OKAY, 1'b0, 3'h0},
		'{OP_WRITE, 8'h12, 32'h0F0F0F0F, 32'h3, 4'h5, RESP_ERROR, 1'b0, 3'h2},
		'{OP_READ, 8'h12, 32'h0, 32'h0, 4'h9, RESP_DEFER, 1'b0, 3'h2},
		'{OP_READ, 8'h12, 32'h0, 32'h0, 4'h8, RESP_ERROR, 1'b1, 3'h3},
		'{OP_CMO, 8'h12, 32'h0, 32'h0, 4'h8, RESP_ERROR, 1'b1, 3'h3},
		'{OP_WRITE, 8'h13, 32'h0, 32'h1, 4'h0, RESP_OKAY, 1'b0, 3'h2},
		'{OP_READ, 8'h12, 32'h0F0F0F0C, 32'h0, 4'h0, RESP_OKAY, 1'b0, 3'h3},
		'{OP_READ, 8'h10, 32'hA5A5A5A5, 32'h10, 4'h8, RESP_OKAY, 1'b0, 3'h6},
		'{OP_CMO, 8'h10, 32'h0, 32'h3, 4'h8, RESP_ERROR, 1'b1, 3'h3}
	};

	// Free-running core clock.
	initial
	begin
		forever #10 clk = ~clk;
	end

	mer_memory_error_response u_dut (
		.i_core_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_rd_resp_en(rd_en),
		.i_wr_resp_en(wr_en), .i_wr_eri_en(eri_en), .i_rd_fhi_en(rd_x),
		.i_rd_eri_en(rd_x), .i_defer_en(defer), .i_req_valid(valid), .i_req(req),
		.o_req_ready(ready), .o_rsp_valid(rsp_v), .o_rsp(rsp), .o_fhi(fhi),
		.o_eri(eri), .o_rec_valid(rec_v), .o_rec(rec)
	);

	mer_pe_model u_pe (
		.i_core_clk(clk), .i_sys_rst(rst), .i_rsp_valid(rsp_v), .i_rsp(rsp),
		.o_done_cnt(done_cnt), .o_err_cnt(err_cnt)
	);

	// Single comparison of any result, widened to one word.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Closing report, also reached when a wait runs out.
	task automatic test_done();
		$display("Mismatches %0d of %0d comparisons", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// One transfer; the answer is awaited for a few cycles at most.
	task automatic xfer(input mer_row_t r);
		int k;
		@(posedge clk);
		{rd_en, wr_en, eri_en, defer} <= r.en;
		rd_x <= r.en[3];
		req <= '{r.op, r.addr, r.wdata, r.flip};
		valid <= 1'b1;
		@(posedge clk);
		valid <= 1'b0;
		@(negedge clk);
		k = 0;
		while (rsp_v !== 1'b1 && k < 4)
		begin
			@(negedge clk);
			k++;
		end
		if (k == 4)
		begin
			bad_count++;
			test_done();
		end
		else
		begin
			chk(32'(rsp.status), 32'(r.st));
			chk(32'(eri), 32'(r.eri));
			chk(32'(fhi), 32'(r.ev[2]));
			chk(32'(rec_v), 32'(r.ev[1]));
			chk(32'(rec.uncontainable), 32'(r.ev[0]));
			if (r.ev[1])
				chk({23'h0, rec.is_write, rec.addr}, {23'h0, r.op == OP_WRITE, r.addr});
			if (r.op == OP_READ && r.st == RESP_OKAY)
				chk(rsp.rdata, r.wdata);
		end
	endtask

	// Main sequence: reset, table rows, then the clock-enable case.
	initial
	begin
		repeat (16) @(posedge clk);
		chk({28'h0, rsp_v, eri, fhi, rec_v}, 32'h0);
		rst <= 1'b0;
		@(negedge clk);
		chk(32'(ready), 32'h1);
		foreach (rows[i])
			xfer(rows[i]);
		// The partner counts a completion at the edge after it is shown.
		@(negedge clk);
		chk(32'(done_cnt), 32'h0D);
		chk(32'(err_cnt), 32'h05);
		@(posedge clk);
		ce <= 1'b0;
		valid <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk(32'(rsp_v), 32'h0);
		chk(32'(done_cnt), 32'h0D);
		@(posedge clk);
		ce <= 1'b1;
		valid <= 1'b0;
		xfer(rows[1]);
		test_done();
	end
endmodule

// ===== sim/mer_pe_model.sv
// Processing element model that counts the completions it accepts.
`timescale 1ns/1ps

module mer_pe_model
	import mer_pkg::*;
(
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// Completing response from the component.
	input wire logic i_rsp_valid,
	input wire mer_rsp_t i_rsp,
	// Completion counts.
	output logic [7:0] o_done_cnt,
	output logic [7:0] o_err_cnt
);
	// An error status completes the transfer just as a normal answer does.
	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			o_done_cnt <= 8'h00;
			o_err_cnt <= 8'h00;
		end
		else if (i_rsp_valid)
		begin
			o_done_cnt <= o_done_cnt + 8'h01;
			o_err_cnt <= o_err_cnt + {7'h00, i_rsp.status == RESP_ERROR};
		end
	end
endmodule

// ===== verilog/mer_memory_error_response.sv
// Memory-side component with granule ECC, poison and error response policy.
// Summary of operation
// [R01] Correctable read error: return corrected data.
// [R02] Maintenance ops follow the read policy.
// [R03] Uncorrectable deferrable read error is deferred.
// [R04] Otherwise read gets error response when enabled.
// [R05] Correctable write error is corrected.
// [R06] Uncorrectable deferrable write error poisons location.
// [R07] Write error gives error response when enabled.
// [R08] Write error raises recovery interrupt when enabled.
// [R09] Read errors may record and interrupt.
// [R10] Errors forwarded to error-record node.
// [R11] Protection granule size is a design parameter; here it is fixed at the 32-bit data word.
// [R12] Poisoned location reads as a detected error.
// [R13] Unknown containability reported as uncontainable.
// [R14] Error status rides on the completing response.
// [R15] Separate enables, all reset to disabled; here they are plain inputs that reset does not touch.
`timescale 1ns/1ps

module mer_memory_error_response
	import mer_pkg::*;
(
	// Clock, reset and enable.
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	// Policy enables, one per path; low is disabled. [R15]
	input wire logic i_rd_resp_en,
	input wire logic i_wr_resp_en,
	input wire logic i_wr_eri_en,
	input wire logic i_rd_fhi_en,
	input wire logic i_rd_eri_en,
	input wire logic i_defer_en,
	// Request from the processing element.
	input wire logic i_req_valid,
	input wire mer_req_t i_req,
	output logic o_req_ready,
	// Completing response.
	output logic o_rsp_valid,
	output mer_rsp_t o_rsp,
	// Interrupts and error-record node.
	output logic o_fhi,
	output logic o_eri,
	output logic o_rec_valid,
	output mer_rec_t o_rec
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// One ECC word per protection granule; granule size is fixed here. [R11]
	logic [DATA_W-1:0] mem_data [DEPTH];
	logic [ECC_W-1:0] mem_ecc [DEPTH];

	// Even-parity Hamming check bits over the 32-bit granule.
	function automatic logic [ECC_W-1:0] ecc_gen(input logic [DATA_W-1:0] d);
		logic [ECC_W-1:0] c;
		int p;
		c = '0;
		p = 3;
		for (int i = 0; i < DATA_W; i++)
		begin
			while ((p & (p - 1)) == 0)
				p++;
			for (int b = 0; b < 6; b++)
				if (p[b])
					c[b] ^= d[i];
			c[6] ^= d[i];
			p++;
		end
		return c;
	endfunction

	// Syndrome decode: returns data bit to flip, or -1 when the syndrome matches no data bit.
	function automatic int ecc_pos(input logic [5:0] syn);
		int p;
		int r;
		p = 3;
		r = -1;
		for (int i = 0; i < DATA_W; i++)
		begin
			while ((p & (p - 1)) == 0)
				p++;
			if (p == int'(syn))
				r = i;
			p++;
		end
		return r;
	endfunction

	// ----------------------------------------
	// Check and policy
	// ----------------------------------------
	logic [ADDR_W-1:0] idx;
	logic [DATA_W-1:0] raw;
	logic [ECC_W-1:0] syn;
	logic [DATA_W-1:0] fixed;
	logic poisoned;
	logic ce_err;
	logic ue_err;
	logic [DATA_W-1:0] wdat;
	logic [ECC_W-1:0] wchk;
	logic [ECC_W-1:0] wsyn;
	logic w_ce;
	logic w_ue;
	logic [DATA_W-1:0] wfix;
	logic is_wr;
	logic fire;

	assign o_req_ready = 1'b1;
	assign fire = i_ce && i_req_valid;
	assign is_wr = (i_req.op == OP_WRITE);
	assign idx = i_req.addr;

	// Stored granule check; a poison code is never a correctable pattern.
	// On reads i_req.flip models a fault on the array read path.
	always_comb
	begin
		int pos;
		pos = -1;
		raw = mem_data[idx] ^ (is_wr ? '0 : i_req.flip);
		syn = ecc_gen(raw) ^ mem_ecc[idx];
		poisoned = (mem_ecc[idx] == (ecc_gen(mem_data[idx]) ^ POISON_SYN)); // R12
		fixed = raw;
		ce_err = 1'b0;
		ue_err = 1'b0;
		if (syn != '0)
		begin
			pos = ecc_pos(syn[5:0]);
			if (!poisoned && syn[6] && pos >= 0)
			begin
				fixed[pos] = ~raw[pos]; // R01
				ce_err = 1'b1;
			end
			else
				ue_err = 1'b1;
		end
	end

	// Write data check; i_req.flip models faults on the incoming transfer.
	always_comb
	begin
		int pos;
		pos = -1;
		wdat = i_req.wdata ^ i_req.flip;
		wchk = ecc_gen(i_req.wdata);
		wfix = wdat;
		w_ce = 1'b0;
		w_ue = 1'b0;
		wsyn = ecc_gen(wdat) ^ wchk;
		if (wsyn != '0)
		begin
			// Only the syndrome decides; a double fault clears the overall parity bit.
			pos = ecc_pos(wsyn[5:0]);
			if (wsyn[6] && pos >= 0)
			begin
				wfix[pos] = ~wdat[pos]; // R05
				w_ce = 1'b1;
			end
			else
				w_ue = 1'b1;
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	logic nxt_rsp_valid;
	mer_rsp_t nxt_rsp;
	logic nxt_fhi;
	logic nxt_eri;
	logic nxt_rec_valid;
	mer_rec_t nxt_rec;
	logic rsp_valid_ff;
	mer_rsp_t rsp_ff;
	logic fhi_ff;
	logic eri_ff;
	logic rec_valid_ff;
	mer_rec_t rec_ff;

	// Decide the answer; reads and maintenance share one path. [R02]
	always_comb
	begin
		nxt_rsp_valid = fire;
		nxt_rsp = '{status: RESP_OKAY, rdata: '0};
		nxt_fhi = 1'b0;
		nxt_eri = 1'b0;
		nxt_rec_valid = 1'b0;
		nxt_rec = '0;
		if (fire)
		begin
			nxt_rec.addr = idx;
			nxt_rec.is_write = is_wr;
			if (!is_wr)
			begin
				nxt_rsp.rdata = fixed; // R01
				nxt_rec.corrected = ce_err;
				if (ue_err && i_defer_en)
					nxt_rsp.status = RESP_DEFER; // R03
				else if (ue_err && i_rd_resp_en)
					nxt_rsp.status = RESP_ERROR; // R04 R14
				nxt_rec.deferred = ue_err && i_defer_en;
				nxt_rec.uncorrected = ue_err && !i_defer_en;
				nxt_fhi = ce_err && i_rd_fhi_en; // R09
				nxt_eri = ue_err && !i_defer_en && i_rd_eri_en; // R09
			end
			else
			begin
				nxt_rec.corrected = w_ce;
				nxt_rec.deferred = w_ue && i_defer_en; // R06
				nxt_rec.uncorrected = w_ue && !i_defer_en;
				if ((w_ce || w_ue) && i_wr_resp_en)
					nxt_rsp.status = RESP_ERROR; // R07 R14
				nxt_eri = (w_ce || w_ue) && i_wr_eri_en; // R08
			end
			// Containment is not tracked here, so uncorrected is uncontainable.
			nxt_rec.uncontainable = nxt_rec.uncorrected; // R13
			nxt_rec_valid = nxt_rec.corrected || nxt_rec.deferred || nxt_rec.uncorrected; // R10
		end
	end

	// Register the answer; enable low freezes everything.
	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			rsp_valid_ff <= 1'b0;
			rsp_ff <= '0;
			fhi_ff <= 1'b0;
			eri_ff <= 1'b0;
			rec_valid_ff <= 1'b0;
			rec_ff <= '0;
		end
		else if (i_ce)
		begin
			rsp_valid_ff <= nxt_rsp_valid;
			rsp_ff <= nxt_rsp;
			fhi_ff <= nxt_fhi;
			eri_ff <= nxt_eri;
			rec_valid_ff <= nxt_rec_valid;
			rec_ff <= nxt_rec;
		end
	end

	// Memory update: uncorrectable write with defer stores poison. [R06]
	always_ff @(posedge i_core_clk)
	begin
		if (fire && is_wr)
		begin
			mem_data[idx] <= wfix;
			if (w_ue && i_defer_en)
				mem_ecc[idx] <= ecc_gen(wfix) ^ POISON_SYN; // R12
			else
				mem_ecc[idx] <= ecc_gen(wfix);
		end
	end

	assign o_rsp_valid = rsp_valid_ff;
	assign o_rsp = rsp_ff;
	assign o_fhi = fhi_ff;
	assign o_eri = eri_ff;
	assign o_rec_valid = rec_valid_ff;
	assign o_rec = rec_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_rsp_one_cycle: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R14
		fire |=> o_rsp_valid)
		else $error("Response missing one cycle after request.");
	a_rd_err_gate: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R04
		(o_rsp_valid && !o_rec.is_write && o_rsp.status == RESP_ERROR && $past(i_ce))
		|-> $past(i_rd_resp_en))
		else $error("Read error response while disabled.");
	a_rd_defer: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R03
		(fire && !is_wr && ue_err && i_defer_en) |=> (o_rsp.status == RESP_DEFER))
		else $error("Deferrable read error not deferred.");
	a_rd_correct: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R01
		(fire && !is_wr && ce_err) |=> (o_rsp.status == RESP_OKAY && o_rec.corrected))
		else $error("Correctable read error not corrected.");
	a_wr_resp: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R07
		(fire && is_wr && w_ue && i_wr_resp_en) |=> (o_rsp.status == RESP_ERROR))
		else $error("Write error response missing.");
	a_wr_eri: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R08
		(o_eri && o_rec.is_write && $past(i_ce)) |-> $past(i_wr_eri_en))
		else $error("Write recovery interrupt while disabled.");
	a_uncont: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R13
		o_rec.uncorrected |-> o_rec.uncontainable)
		else $error("Uncorrected error not marked uncontainable.");
	a_rec_fwd: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R10
		(fire && (ce_err || ue_err) && !is_wr) |=> o_rec_valid)
		else $error("Read error not forwarded to record node.");
	a_rd_eri_gate: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R09
		(o_eri && !o_rec.is_write && $past(i_ce)) |-> $past(i_rd_eri_en))
		else $error("Read recovery interrupt while disabled.");
	a_fhi_gate: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R09
		(o_fhi && $past(i_ce)) |-> ($past(i_rd_fhi_en) && o_rec.corrected))
		else $error("Fault handling pulse without an enabled correction.");
	a_wr_fix: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R05
		(fire && is_wr && w_ce) |-> (wfix == i_req.wdata))
		else $error("Correctable write error not corrected.");
	a_poison_det: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R12
		(fire && !is_wr && poisoned) |-> ue_err)
		else $error("Poisoned location not treated as an error.");
	a_rsp_pulse: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R14
		(o_rsp_valid && i_ce && !i_req_valid) |=> !o_rsp_valid)
		else $error("Response stood longer than one enabled cycle.");

endmodule

// ===== verilog/mer_pkg.sv
// Package of types and constants for the memory error response block.
package mer_pkg;

	// ----------------------------------------
	// Widths and encodings
	// ----------------------------------------
	localparam int DATA_W = 32;
	localparam int ECC_W = 7;
	localparam int GRAN_BYTES = 4;
	localparam int ADDR_W = 8;
	localparam int DEPTH = 256;
	localparam logic [ECC_W-1:0] POISON_SYN = 7'h7F;

	// Operation kinds from the processing element.
	typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_CMO} mer_op_t;

	// Response status returned on the completing response.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DEFER = 2'h1;
	localparam logic [1:0] RESP_ERROR = 2'h2;

	// Request from the processing element.
	typedef struct packed {
		mer_op_t op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] flip;
	} mer_req_t;

	// Completing response to the processing element.
	typedef struct packed {
		logic [1:0] status;
		logic [DATA_W-1:0] rdata;
	} mer_rsp_t;

	// Event forwarded to the error-record node.
	typedef struct packed {
		logic corrected;
		logic deferred;
		logic uncorrected;
		logic uncontainable;
		logic is_write;
		logic [ADDR_W-1:0] addr;
	} mer_rec_t;

endpackage
